/* File: decrement_file_unit.v */
// Purpose: executes decrement_file and decrement_skip_if_zero
// Assumes: one instruction per four-phase cycle, file memory inside this unit
// Notes:   other opcodes are ignored apart from advancing the program counter
//
// Summary of operation
// RULE1 - opcode class 000011 with destination bit and 7-bit address decrements a file register.
// RULE2 - address spans 0 to 127 and destination select is a single bit.
// RULE3 - destination 0 writes the result to the working register and leaves the file alone.
// RULE4 - decrement_file updates only the zero flag.
// RULE5 - decrement_skip_if_zero takes one cycle, plus a no-operation cycle when the result is zero.
// RULE6 - the program counter skips the next instruction on a zero result, else steps by one; the code always steps by one and runs that slot as a no-op.
// RULE7 - destination 1 writes the result back into the addressed file register.
// RULE8 - zero flag is set exactly when the eight-bit result is zero, for either destination.
`include "decrement_op_defines.vh"
`default_nettype none
module decrement_file_unit #(
   parameter DEPTH = 128
) (
   input  wire                    clk_i,      // 40 MHz core clock
   input  wire                    rst_i,      // async reset, active high
   input  wire                    ce_i,       // clock enable, freezes all state
   input  wire [`OPC_WIDTH-1:0]   opcode_i,   // instruction word, taken at Q1
   output reg  [`DATA_WIDTH-1:0]  w_o,        // working register
   output reg                     zero_o,     // zero flag
   output reg  [`PC_WIDTH-1:0]    pc_o,       // program counter
   output reg  [3:0]              q_o,        // one-hot phase Q1..Q4
   output reg                     nop_o       // current cycle is a forced no-op
);
   localparam Q1 = 4'h1;
   localparam Q2 = 4'h2;
   localparam Q3 = 4'h4;
   localparam Q4 = 4'h8;

   wire [`DATA_WIDTH-1:0] rd_word [0:DEPTH-1];
   reg  [`OPC_WIDTH-1:0]  ir_r;
   reg  [`DATA_WIDTH-1:0] opnd_r;
   reg  [`DATA_WIDTH-1:0] res_r;
   reg                    res_zero_r;
   wire [`DATA_WIDTH-1:0] alu_res;
   wire                   alu_zero;

   wire [5:0]             cls  = ir_r[`OPC_CLASS_HI:`OPC_CLASS_LO];
   wire                   dest = ir_r[`OPC_DEST_BIT];                  // RULE2
   wire [`ADDR_WIDTH-1:0] addr = ir_r[`OPC_ADDR_HI:`OPC_ADDR_LO];      // RULE2
   wire                   is_dec  = (cls == `OPC_DEC_FILE);           // RULE1
   wire                   is_skip = (cls == `OPC_DEC_SKIP);
   wire                   is_any  = is_dec | is_skip;
   wire [`PC_WIDTH-1:0]   pc_one  = {{(`PC_WIDTH-1){1'b0}}, 1'b1};

   dec_alu #(.WIDTH(`DATA_WIDTH)) u_alu (
      .operand_i (opnd_r),
      .result_o  (alu_res),
      .zero_o    (alu_zero)
   );

   wire                   file_we = (q_o == Q4) && !nop_o && is_any && (dest == `DEST_F);

   // every cell resets so a decrement never reads an unknown byte; costs a reset net per cell
   genvar g;
   generate
      for (g = 0; g < DEPTH; g = g + 1) begin : g_cell
         reg [`DATA_WIDTH-1:0] cell_r;
         always @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               cell_r <= `FILE_RESET;
            end else if (ce_i && file_we && ({{(32-`ADDR_WIDTH){1'b0}}, addr} == g)) begin
               cell_r <= res_r; // RULE7
            end
         end
         assign rd_word[g] = cell_r;
      end
   endgenerate

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q_o        <= Q1;
         ir_r       <= {`OPC_WIDTH{1'b0}};
         opnd_r     <= {`DATA_WIDTH{1'b0}};
         res_r      <= {`DATA_WIDTH{1'b0}};
         res_zero_r <= 1'b0;
         w_o        <= `W_RESET;
         zero_o     <= `Z_RESET;
         pc_o       <= `PC_RESET;
         nop_o      <= 1'b0;
      end else if (ce_i) begin
         case (q_o)
            Q1: begin
               // decode; a skipped slot keeps its word but never executes it
               ir_r <= opcode_i;
               q_o  <= Q2;
            end
            Q2: begin
               opnd_r <= rd_word[addr]; // RULE1
               q_o    <= Q3;
            end
            Q3: begin
               res_r      <= alu_res;
               res_zero_r <= alu_zero;
               q_o        <= Q4;
            end
            Q4: begin
               q_o <= Q1;
               if (nop_o) begin
                  nop_o <= 1'b0; // RULE5
                  pc_o  <= pc_o + pc_one;
               end else begin
                  if (is_any && dest == `DEST_W) begin
                     w_o <= res_r; // RULE3
                  end
                  if (is_dec) begin
                     zero_o <= res_zero_r; // RULE4 RULE8
                  end
                  if (is_skip && res_zero_r) begin
                     // the following instruction is fetched but discarded
                     nop_o <= 1'b1; // RULE5
                  end
                  pc_o <= pc_o + pc_one; // RULE6
               end
            end
            default: begin
               q_o <= Q1;
            end
         endcase
      end
   end
endmodule // decrement_file_unit
`default_nettype wire

/* File: decrement_op_defines.vh */
// Purpose: constants for the file-register decrement execution unit
// Assumes: 14-bit opcodes, 8-bit data, 7-bit file addresses
// Notes:   included by decrement_file_unit.v and dec_alu.v
`ifndef DECREMENT_OP_DEFINES_VH
`define DECREMENT_OP_DEFINES_VH
`define OPC_WIDTH        14
`define OPC_CLASS_HI     13
`define OPC_CLASS_LO     8
`define OPC_DEST_BIT     7
`define OPC_ADDR_HI      6
`define OPC_ADDR_LO      0
`define OPC_DEC_FILE     6'h03
`define OPC_DEC_SKIP     6'h0B
`define DATA_WIDTH       8
`define ADDR_WIDTH       7
`define DEST_W           1'b0
`define DEST_F           1'b1
`define W_RESET          8'h00
`define FILE_RESET       8'h00
`define Z_RESET          1'b0
`define PC_WIDTH         13
`define PC_RESET         13'h0000
`define Q_RESET          4'h1
`endif

/* File: dec_alu.v */
// Purpose: eight-bit decrement with zero detect
// Assumes: purely combinational
// Notes:   wraps 00 to FF
`include "decrement_op_defines.vh"
`default_nettype none
module dec_alu #(
   parameter WIDTH = `DATA_WIDTH
) (
   input  wire [WIDTH-1:0] operand_i, // value read from file register
   output wire [WIDTH-1:0] result_o,  // operand minus one
   output wire             zero_o     // result equals zero
);
   wire [WIDTH-1:0] one = {{(WIDTH-1){1'b0}}, 1'b1};
   assign result_o = operand_i - one;
   assign zero_o   = (result_o == {WIDTH{1'b0}}); // RULE8
endmodule // dec_alu
`default_nettype wire

/* File: dec_unit_chk.sv */
// Purpose: port checker for decrement_file_unit
// Assumes: ce_i held high by the bench apart from one three-cycle stall
// Notes: case equality, so an unknown output counts as a failure
`default_nettype none
module dec_unit_chk (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   input wire logic [13:0] opcode_i,
   input wire logic [7:0]  w_o,
   input wire logic        zero_o,
   input wire logic [12:0] pc_o,
   input wire logic [3:0]  q_o,
   input wire logic        nop_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take(c, d);
      q_o == 4'h1 && ce_i && !nop_o && opcode_i[13:8] == c && opcode_i[7] == d;
   endsequence
   a_phase_rotate: assert property (ce_i |=> q_o == {$past(q_o[2:0]), $past(q_o[3])})
      else $error("phase did not rotate");
   a_pc_step: assert property (q_o == 4'h8 && ce_i |=> pc_o === $past(pc_o) + 13'h1)
      else $error("pc did not step");
   a_outputs_hold: assert property (q_o != 4'h8 |=> $stable(pc_o) && $stable(w_o))
      else $error("outputs moved off Q4");
   a_skip_nop: assert property (s_take(6'h0B, 1'b0) |-> ##4
      nop_o === (w_o == 8'h00) && zero_o === $past(zero_o, 4)) else $error("skip wrong");
   a_dec_flag: assert property (s_take(6'h03, 1'b0) |-> ##4 zero_o === (w_o == 8'h00))
      else $error("zero flag wrong");
   a_dest_file: assert property (s_take(6'h03, 1'b1) |-> ##4 w_o === $past(w_o, 4))
      else $error("working reg written");
   a_nop_len: assert property ($rose(nop_o) |-> nop_o[*4] ##1 !nop_o)
      else $error("nop length");
   a_skip_file: assert property (s_take(6'h0B, 1'b1) |-> ##4
      w_o === $past(w_o, 4) && zero_o === $past(zero_o, 4)) else $error("skip to file wrong");
   a_other_idle: assert property (q_o == 4'h1 && opcode_i[13:12] != 2'b00 |-> ##4
      w_o === $past(w_o, 4) && zero_o === $past(zero_o, 4)) else $error("other op wrote");
endmodule // dec_unit_chk
bind decrement_file_unit dec_unit_chk u_dec_unit_chk (.clk_i(clk_i), .rst_i(rst_i),
   .ce_i(ce_i), .opcode_i(opcode_i), .w_o(w_o), .zero_o(zero_o), .pc_o(pc_o), .q_o(q_o),
   .nop_o(nop_o));
`default_nettype wire

/* File: test_decrement_file_unit.sv */
// Purpose: random and corner tests of decrement_file_unit
// Assumes: ce_i high except during one three-cycle stall
// Notes: file memory resets to zero, so a byte-wide model tracks every cell
`default_nettype none
module test_decrement_file_unit;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, exp_z = 1'b0, exp_nop = 1'b0;
   logic [13:0] opcode_i = 14'h0000, op;
   logic [12:0] exp_pc = 13'h0000;
   logic [7:0]  exp_w = 8'h00;
   logic [7:0]  mem [0:127];
   logic [31:0] rnd;
   wire logic [7:0]  w_o;
   wire logic [12:0] pc_o;
   wire logic [3:0]  q_o;
   wire logic        zero_o, nop_o;
   int miscompares = 0, compares = 0;
   decrement_file_unit u_decrement_file_unit (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .opcode_i(opcode_i), .w_o(w_o), .zero_o(zero_o), .pc_o(pc_o), .q_o(q_o), .nop_o(nop_o));
   initial forever #12.5 clk_i = ~clk_i;
   function automatic logic [7:0] dec8(input logic [7:0] v);
      return v - 8'h01;
   endfunction
   task automatic check(input string n, input logic [12:0] e, s);
      compares++;
      if (e !== s) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic model_reset;
      foreach (mem[k]) mem[k] = 8'h00;
      exp_w = 8'h00;
      exp_z = 1'b0;
      exp_nop = 1'b0;
      exp_pc = 13'h0000;
   endtask
   task automatic run_op(input logic [13:0] o);
      logic [7:0] r;
      while (q_o !== 4'h1) @(negedge clk_i);
      opcode_i = o;
      repeat (4) @(negedge clk_i);
      exp_pc++;
      r = dec8(mem[o[6:0]]);
      if (exp_nop) begin
         exp_nop = 1'b0; // slot after a taken skip executes nothing
      end else if (o[13:8] == 6'h03 || o[13:8] == 6'h0B) begin
         if (o[7]) mem[o[6:0]] = r;
         else exp_w = r;
         if (o[13:8] == 6'h03) exp_z = (r == 8'h00);
         else exp_nop = (r == 8'h00);
      end
      check("pc", exp_pc, pc_o);
      check("w", 13'(exp_w), 13'(w_o));
      check("zero", 13'(exp_z), 13'(zero_o));
      check("nop", 13'(exp_nop), 13'(nop_o));
   endtask
   task automatic stall(input int n);
      opcode_i = 14'h0000;
      ce_i = 1'b0;
      repeat (n) @(negedge clk_i);
      ce_i = 1'b1;
      check("stall pc", exp_pc, pc_o);
      check("stall q", 13'h0001, 13'(q_o));
   endtask
   task automatic do_reset;
      rst_i = 1'b1;
      @(negedge clk_i);
      rst_i = 1'b0;
      model_reset();
      check("rst pc", 13'h0000, pc_o);
      check("rst w", 13'h0000, 13'(w_o));
   endtask
   task automatic print_verdict;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #200us;
      miscompares++;
      print_verdict();
   end
   initial begin
      void'($urandom(32'h9B7048D9));
      model_reset();
      repeat (2) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (255) run_op({6'h03, 1'b1, 7'h7F});
      run_op({6'h03, 1'b0, 7'h7F});
      run_op({6'h0B, 1'b1, 7'h7F});
      run_op({6'h03, 1'b0, 7'h7F});
      run_op({6'h0B, 1'b0, 7'h7F});
      stall(3);
      do_reset();
      for (int i = 0; i < 150; i++) begin
         rnd = $urandom;
         op = 14'(rnd >> 8);
         if (rnd[1]) op[13:8] = rnd[0] ? 6'h0B : 6'h03;
         if (rnd[2]) op[6:0] = rnd[3] ? 7'h7F : 7'(rnd[5:4]);
         run_op(op);
      end
      print_verdict();
   end
endmodule // test_decrement_file_unit
`default_nettype wire
